// >>> rtl/vpic_defines.svh
// Constants of the vectored priority interrupt controller.
`ifndef VPIC_DEFINES_SVH
`define VPIC_DEFINES_SVH
`define VPIC_NUM_TRAPS 8
`define VPIC_NUM_IRQS 118
`define VPIC_NUM_VECT 126
`define VPIC_PRIO_W 3
`define VPIC_VEC_W 7
`define VPIC_ADDR_W 24
`define VPIC_PRIM_BASE 24'h000004
`define VPIC_ALT_BASE 24'h000084
`define VPIC_RESET_ADDR 24'h000000
`define VPIC_ALT_BIT 15
`define VPIC_PRIO_RST 3'h4
`define VPIC_ENTRY_LAT 2
`define VPIC_RET_LAT 2
`define VPIC_REG_CTRL2 8'h00
`define VPIC_REG_STAT 8'h01
`define VPIC_REG_FLAG 8'h02
`define VPIC_REG_ENA 8'h03
`define VPIC_REG_PRIO 8'h04
`define VPIC_REG_FCLR 8'h05
`define VPIC_REG_FSET 8'h06
`define VPIC_REG_TRAP 8'h07
`endif

// >>> rtl/vpic_pkg.sv
// Types of the vectored priority interrupt controller.
package vpic_pkg;
  typedef enum logic [1:0] {
    VPIC_IDLE,
    VPIC_ENTRY,
    VPIC_SERVE,
    VPIC_RETURN
  } vpic_state_t;
endpackage

// >>> rtl/vpic_ctrl.sv
// Vectored priority interrupt controller with register port.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "vpic_defines.svh"

// Contract
// RULE1 - All peripheral request lines are merged into one core request.
// RULE2 - Eight trap sources are handled besides the peripheral sources.
// RULE3 - Each maskable source has a software priority of seven levels.
// RULE4 - The primary table starts at word address 000004h.
// RULE5 - The table holds 126 entries, eight traps then 118 sources.
// RULE6 - Each source has its own distinct vector entry.
// RULE7 - Each entry is a 24-bit service routine start address.
// RULE8 - At equal priority the lower vector number wins.
// RULE9 - Arbitration order within one level is fixed.
// RULE10 - Entry and return latencies are each a fixed cycle count.
// RULE11 - The alternate table follows the primary one with equal layout.
// RULE12 - Bit 15 of control register two selects the alternate table.
// RULE13 - Device reset bypasses the controller and starts at 000000h.
// RULE14 - Priority fields are three bits, 111 highest and 001 lowest.
// RULE15 - A source with priority 000 never raises a request.
// RULE16 - A source competes only with its flag and enable both set; the code lets traps compete on their flag alone.
// RULE17 - The request rises only above core priority; traps always win.
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter int NUM_IRQS = `VPIC_NUM_IRQS,
  parameter int NUM_TRAPS = `VPIC_NUM_TRAPS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sources.
  input wire logic [NUM_IRQS-1:0] irq_pulse,
  input wire logic [NUM_TRAPS-1:0] trap_pulse,
  // Core side.
  input wire logic [2:0] core_prio,
  input wire logic core_ack,
  input wire logic core_ret,
  output logic core_req,
  output logic [`VPIC_ADDR_W-1:0] vector_addr,
  output logic [6:0] vector_num,
  output logic in_service
);

  localparam int IDXW = 7;
  localparam int LAT_E = `VPIC_ENTRY_LAT;
  localparam int LAT_R = `VPIC_RET_LAT;

  logic [NUM_IRQS-1:0] flag;
  logic [NUM_IRQS-1:0] enable;
  logic [2:0] prio [NUM_IRQS];
  logic [NUM_TRAPS-1:0] trap_flag;
  logic alt_table_select;
  logic [IDXW-1:0] sel;
  vpic_state_t state;
  logic [1:0] lat_cnt;
  logic [6:0] win_num;
  logic [2:0] win_prio;
  logic win_valid;
  logic win_trap;
  logic [NUM_IRQS-1:0] clr_irq;
  logic [NUM_TRAPS-1:0] clr_trap;

  // Entry address: table base plus index; both tables share one layout.
  function automatic logic [23:0] vec_addr(input logic alt,
                                           input logic [6:0] num);
    logic [23:0] base;
    base = alt ? `VPIC_ALT_BASE : `VPIC_PRIM_BASE; // RULE11 RULE12
    vec_addr = base + {17'h00000, num}; // RULE4 RULE6 RULE7
  endfunction

  // Traps take numbers 0..7, peripherals follow from 8 upward.
  always_comb begin // RULE5 RULE8 RULE9 RULE16 RULE2
    win_valid = 1'b0;
    win_trap = 1'b0;
    win_num = 7'h00;
    win_prio = 3'h0;
    for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
      if (trap_flag[t]) begin
        win_valid = 1'b1;
        win_trap = 1'b1;
        win_num = 7'(t);
      end
    end
    if (!win_trap) begin
      for (int i = NUM_IRQS - 1; i >= 0; i--) begin
        // Ties keep the later, lower-numbered hit; scan runs downward.
        if (flag[i] && enable[i] && prio[i] != 3'h0 && // RULE15 RULE14
            prio[i] >= win_prio) begin // RULE3
          win_valid = 1'b1;
          win_prio = prio[i];
          win_num = 7'(i + NUM_TRAPS);
        end
      end
    end
  end

  // Acknowledge clears the flag of the vector the core was shown, not the
  // live winner, which may have moved on in that cycle; a new event wins.
  always_comb begin
    clr_irq = '0;
    clr_trap = '0;
    if (state == VPIC_IDLE && core_ack && core_req) begin
      if (vector_num < 7'(NUM_TRAPS)) begin
        clr_trap[vector_num[2:0]] = 1'b1;
      end else begin
        clr_irq[vector_num - 7'(NUM_TRAPS)] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trap_flag <= '0;
    end else begin
      trap_flag <= (trap_flag & ~clr_trap) | trap_pulse;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag <= '0;
    end else begin
      if (reg_wr && reg_addr == `VPIC_REG_FCLR &&
          32'(reg_wdata[6:0]) < NUM_IRQS) begin
        flag <= ((flag & ~clr_irq) & ~(NUM_IRQS'(1) << reg_wdata[6:0]))
                | irq_pulse;
      end else if (reg_wr && reg_addr == `VPIC_REG_FSET &&
                   32'(reg_wdata[6:0]) < NUM_IRQS) begin
        flag <= (flag & ~clr_irq) | irq_pulse |
                (NUM_IRQS'(1) << reg_wdata[6:0]);
      end else begin
        flag <= (flag & ~clr_irq) | irq_pulse;
      end
    end
  end

  // Enable and priority are reached indirectly through a source index.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel <= '0;
      enable <= '0;
      alt_table_select <= 1'b0;
      for (int i = 0; i < NUM_IRQS; i++) begin
        prio[i] <= `VPIC_PRIO_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == `VPIC_REG_CTRL2) begin
        alt_table_select <= reg_wdata[`VPIC_ALT_BIT]; // RULE12
        sel <= reg_wdata[6:0];
      end else if (reg_addr == `VPIC_REG_ENA &&
                   32'(sel) < NUM_IRQS) begin
        enable[sel] <= reg_wdata[0];
      end else if (reg_addr == `VPIC_REG_PRIO &&
                   32'(sel) < NUM_IRQS) begin
        prio[sel] <= reg_wdata[2:0]; // RULE14
      end
    end
  end

  // Fixed latencies: counts do not depend on source or table.
  always_ff @(posedge clk or negedge nrst) begin // RULE10
    if (!nrst) begin
      state <= VPIC_IDLE;
      lat_cnt <= '0;
    end else begin
      case (state)
        VPIC_IDLE: begin
          if (core_ack && core_req) begin
            state <= VPIC_ENTRY;
            lat_cnt <= 2'(LAT_E - 1);
          end
        end
        VPIC_ENTRY: begin
          if (lat_cnt == 2'h0) begin
            state <= VPIC_SERVE;
          end else begin
            lat_cnt <= lat_cnt - 2'h1;
          end
        end
        VPIC_SERVE: begin
          if (core_ret) begin
            state <= VPIC_RETURN;
            lat_cnt <= 2'(LAT_R - 1);
          end
        end
        VPIC_RETURN: begin
          if (lat_cnt == 2'h0) begin
            state <= VPIC_IDLE;
          end else begin
            lat_cnt <= lat_cnt - 2'h1;
          end
        end
        default: begin
          state <= VPIC_IDLE;
        end
      endcase
    end
  end

  // Reset leaves the vector at the reset address, not a table entry.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_req <= 1'b0;
      vector_num <= 7'h00;
      vector_addr <= `VPIC_RESET_ADDR; // RULE13
      in_service <= 1'b0;
    end else begin
      in_service <= (state == VPIC_SERVE) ||
                    (state == VPIC_ENTRY && lat_cnt == 2'h0);
      if (state == VPIC_IDLE && !(core_ack && core_req)) begin
        core_req <= win_valid && (win_trap || win_prio > core_prio); // RULE1 RULE17
        vector_num <= win_num;
        vector_addr <= vec_addr(alt_table_select, win_num);
      end else begin
        core_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `VPIC_REG_CTRL2: reg_rdata <= {alt_table_select, 8'h00, sel};
        `VPIC_REG_STAT: reg_rdata <= {win_valid, win_trap, 1'b0,
                                      win_prio, 3'h0, win_num};
        `VPIC_REG_FLAG: reg_rdata <= (32'(sel) < NUM_IRQS) ?
                                     {15'h0000, flag[sel]} : 16'h0000;
        `VPIC_REG_ENA: reg_rdata <= (32'(sel) < NUM_IRQS) ?
                                    {15'h0000, enable[sel]} : 16'h0000;
        `VPIC_REG_PRIO: reg_rdata <= (32'(sel) < NUM_IRQS) ?
                                     {13'h0000, prio[sel]} : 16'h0000;
        `VPIC_REG_TRAP: reg_rdata <= {8'h00, trap_flag};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // A disabled-priority source must never cause a request.
  no_zero_prio_a: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    $rose(core_req) && vector_num >= 7'(NUM_TRAPS) |->
      $past(win_prio) != 3'h0) else $error("zero prio request");
  req_above_core_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(core_req) && vector_num >= 7'(NUM_TRAPS) |->
      $past(win_prio) > $past(core_prio)) else $error("prio low"); // RULE17
  addr_matches_num_a: assert property (@(posedge clk) disable iff (!nrst)
    core_req |-> vector_addr == vec_addr(alt_table_select, vector_num) ||
    $changed(alt_table_select)) else $error("vector addr"); // RULE7
  entry_latency_a: assert property (@(posedge clk) disable iff (!nrst)
    state == VPIC_IDLE && core_ack && core_req |->
      ##(LAT_E + 1) state == VPIC_SERVE) else $error("entry lat"); // RULE10
  return_latency_a: assert property (@(posedge clk) disable iff (!nrst)
    state == VPIC_SERVE && core_ret |->
      ##(LAT_R + 1) state == VPIC_IDLE) else $error("return lat"); // RULE10
  trap_first_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(core_req) && $past(trap_flag) != '0 |->
      vector_num < 7'(NUM_TRAPS)) else $error("trap lost"); // RULE17
  alt_base_a: assert property (@(posedge clk) disable iff (!nrst)
    core_req && alt_table_select && $stable(alt_table_select) |->
      vector_addr >= `VPIC_ALT_BASE) else $error("alt table"); // RULE12
  event_kept_a: assert property (@(posedge clk) disable iff (!nrst)
    irq_pulse[0] |=> flag[0]) else $error("event lost"); // RULE16
  prim_base_a: assert property (@(posedge clk) disable iff (!nrst)
    core_req && !alt_table_select && $stable(alt_table_select) |->
      vector_addr < `VPIC_ALT_BASE) else $error("prim table"); // RULE4

  // The request is only ever raised from the idle state.
  req_when_idle_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    core_req |-> state == VPIC_IDLE) else $error("req while busy");

  // An accepted request drops at once and entry starts.
  ack_drops_req_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    $fell(core_req) && $past(core_ack) |->
      state == VPIC_ENTRY) else $error("ack not taken");

  // The service flag only stands around a running routine.
  service_span_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    in_service |-> state == VPIC_SERVE || state == VPIC_RETURN)
    else $error("stray service");

  // While serving, the core must see the routine as entered.
  serve_flag_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    state == VPIC_SERVE |-> in_service) else $error("serve flag low");

  // The service flag rises exactly when serving begins.
  service_rise_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    $rose(in_service) |-> state == VPIC_SERVE) else $error("late entry");

  // An acknowledged trap loses its flag unless it fires again.
  trap_cleared_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    state == VPIC_IDLE && core_ack && core_req &&
    vector_num < 7'(NUM_TRAPS) && trap_pulse == '0 |=>
      !trap_flag[vector_num[2:0]]) else $error("trap not cleared");

  // An acknowledged source loses its own flag unless it fires again.
  irq_cleared_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    state == VPIC_IDLE && core_ack && core_req && !reg_wr &&
    vector_num >= 7'(NUM_TRAPS) && irq_pulse == '0 |=>
      !flag[vector_num - 7'(NUM_TRAPS)]) else $error("flag not cleared");

  // Vector numbers never run past the end of the table.
  vector_range_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
    vector_num < 7'(`VPIC_NUM_VECT)) else $error("vector range");

  // A request always stems from a valid winner.
  req_has_winner_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
    $rose(core_req) |-> $past(win_valid)) else $error("no winner");

  // The vector handed over must not move while the core enters.
  entry_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    state == VPIC_ENTRY |-> $stable(vector_num)) else $error("vector moved");

  // Requested addresses stay inside the two tables.
  addr_window_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    core_req |-> vector_addr >= `VPIC_PRIM_BASE &&
      vector_addr < `VPIC_ALT_BASE + 24'h000080) else $error("addr window");

  trap_req_c: cover property (@(posedge clk) disable iff (!nrst)
    core_req && vector_num < 7'(NUM_TRAPS));
  irq_req_c: cover property (@(posedge clk) disable iff (!nrst)
    core_req && vector_num >= 7'(NUM_TRAPS));
  alt_req_c: cover property (@(posedge clk) disable iff (!nrst)
    core_req && alt_table_select);
  full_cycle_c: cover property (@(posedge clk) disable iff (!nrst)
    state == VPIC_RETURN ##[1:4] state == VPIC_IDLE);
  slow_ack_c: cover property (@(posedge clk) disable iff (!nrst)
    core_req ##1 core_req ##1 core_req ##1 core_req);

endmodule

// >>> verif/vpic_core_model.sv
// Behavioural processor core that takes requests and runs short routines.
`timescale 1ns/100ps
module vpic_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Controller side.
  input wire logic core_req,
  input wire logic in_service,
  output logic core_ack,
  output logic core_ret,
  // Cycles to wait before acknowledging.
  input wire logic [3:0] ack_wait
);
  logic [3:0] cnt;
  logic [3:0] run;
  logic done;
  // The acknowledge stands one cycle, while the request is still seen high.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (core_ack || !core_req) begin
      core_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt == ack_wait) begin
      core_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // One return per routine, so a late in_service drop cannot retrigger it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_ret <= 1'b0;
      run <= 4'h0;
      done <= 1'b0;
    end else if (!in_service) begin
      core_ret <= 1'b0;
      run <= 4'h0;
      done <= 1'b0;
    end else if (core_ret) begin
      core_ret <= 1'b0;
      done <= 1'b1;
    end else if (!done && run == 4'h3) begin
      core_ret <= 1'b1;
    end else begin
      run <= run + 4'h1;
    end
  end
endmodule

// >>> verif/vpic_ctrl_bench.sv
// Self-checking bench of the interrupt controller.
`timescale 1ns/100ps
`include "vpic_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  bad_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module vpic_ctrl_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [117:0] irq_pulse = '0;
  logic [7:0] trap_pulse = 8'h00;
  logic [2:0] core_prio = 3'h0;
  logic [3:0] ack_wait = 4'h0;
  logic [15:0] reg_rdata;
  logic core_ack, core_ret, core_req, in_service;
  logic [`VPIC_ADDR_W-1:0] vector_addr;
  logic [6:0] vector_num;
  int bad_count = 0;
  int n_compared = 0;
  int ent_ref = -1;
  int ret_ref = -1;
  int k;
  always #5 clk = ~clk;
  vpic_ctrl u_vpic_ctrl (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pulse(irq_pulse), .trap_pulse(trap_pulse),
    .core_prio(core_prio), .core_ack(core_ack), .core_ret(core_ret),
    .core_req(core_req), .vector_addr(vector_addr),
    .vector_num(vector_num), .in_service(in_service));
  vpic_core_model u_vpic_core_model (.clk(clk), .nrst(nrst),
    .core_req(core_req), .in_service(in_service), .core_ack(core_ack),
    .core_ret(core_ret), .ack_wait(ack_wait));
  task stop_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, exp)
  endtask
  task cfg(input logic [6:0] s, input logic en, input logic [2:0] p);
    wr(8'h00, {9'h000, s});
    wr(8'h03, {15'h0000, en});
    wr(8'h04, {13'h0000, p});
  endtask
  task fire(input logic [117:0] m, input logic [7:0] t);
    @(posedge clk);
    irq_pulse <= m;
    trap_pulse <= t;
    @(posedge clk);
    irq_pulse <= '0;
    trap_pulse <= 8'h00;
  endtask
  // Entry and return spans must repeat exactly, whatever the ack delay.
  task serve(input logic [6:0] n, input logic [23:0] a);
    for (k = 0; k < 40 && core_req !== 1'b1; k++) @(negedge clk);
    `CHK(core_req, 1'b1)
    `CHK(vector_num, n)
    `CHK(vector_addr, a)
    for (k = 0; k < 20 && core_ack !== 1'b1; k++) @(negedge clk);
    for (k = 1; k < 20; k++) begin
      @(negedge clk);
      if (in_service === 1'b1) break;
    end
    if (ent_ref < 0) ent_ref = k;
    `CHK(k, ent_ref)
    for (k = 0; k < 20 && core_ret !== 1'b1; k++) @(negedge clk);
    for (k = 1; k < 20; k++) begin
      @(negedge clk);
      if (in_service === 1'b0) break;
    end
    if (ret_ref < 0) ret_ref = k;
    `CHK(k, ret_ref)
  endtask
  task quiet;
    repeat (8) begin
      @(negedge clk);
      `CHK(core_req, 1'b0)
    end
  endtask
  task t_reset;
    `CHK(vector_addr, 24'h000000)
    `CHK(core_req, 1'b0)
    wr(8'h00, 16'h0005);
    rd(8'h04, 16'h0004);
    rd(8'h03, 16'h0000);
    rd(8'h20, 16'h0000);
  endtask
  task t_order;
    cfg(7'h00, 1'b1, 3'h4);
    fire(118'h1, 8'h00);
    serve(7'd8, 24'h00000c);
    cfg(7'h01, 1'b1, 3'h5);
    cfg(7'h02, 1'b1, 3'h5);
    fire(118'h6, 8'h00);
    serve(7'd9, 24'h00000d);
    ack_wait <= 4'h5;
    serve(7'd10, 24'h00000e);
    cfg(7'h02, 1'b1, 3'h6);
    fire(118'h6, 8'h00);
    serve(7'd10, 24'h00000e);
    ack_wait <= 4'h0;
    serve(7'd9, 24'h00000d);
  endtask
  task t_gate;
    cfg(7'h04, 1'b1, 3'h0);
    cfg(7'h05, 1'b0, 3'h7);
    cfg(7'h06, 1'b1, 3'h3);
    core_prio <= 3'h3;
    fire(118'h70, 8'h00);
    quiet();
    rd(8'h01, 16'h8c0e);
    wr(8'h00, 16'h0005);
    rd(8'h02, 16'h0001);
    wr(8'h05, 16'h0005);
    rd(8'h02, 16'h0000);
    core_prio <= 3'h2;
    serve(7'd14, 24'h000012);
    core_prio <= 3'h7;
    fire(118'h0, 8'h04);
    serve(7'd2, 24'h000006);
    core_prio <= 3'h0;
    cfg(7'h07, 1'b1, 3'h7);
    fire(118'h80, 8'h80);
    serve(7'd7, 24'h00000b);
    serve(7'd15, 24'h000013);
  endtask
  task t_alt;
    cfg(7'd117, 1'b1, 3'h1);
    wr(8'h00, 16'h8075);
    fire(118'h1 << 117, 8'h00);
    serve(7'd125, 24'h000101);
    fire(118'h0, 8'h01);
    serve(7'd0, 24'h000084);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_order();
    t_gate();
    t_alt();
    stop_test();
  end
  // The tests need a few hundred cycles; this leaves a wide margin.
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
